/* File: design/dmf_msg_frag.sv */
// Function
// - A message holds at most 4096 bytes in one or more fragments.
// - A fragment is one header request, then optional data requests.
// - Every fragment but the last carries a multiple of 128 bytes.
// - Data requests carry 64 bytes except the very last one.
// - Messages route by bus and device number, type 0 and 1.
// - Type 1 passes both ways, becoming type 0 on the destination bus.
// - Destination device and function select the receiving function.
// - Count gives the payload doublewords of one request, minus one.
// - Initial Fragment is set only on a message's first fragment.
// - Silent Drop discards unsupported messages without error.
// - Route Type sends the message to the host; destination ignored.
// - Translation Permitted gates forwarding across bus families.
// - Chain marks that more requests of this fragment follow.
// - Nothing is inserted between the requests of one fragment.
// - Messages and fragments of any legal length are accepted.
// - The first request of a fragment carries only header data.
// - A payload-less message is one header with Chain clear.
// - Byte count 001h is one byte, 000h means 4096.
// - Each header's byte count is the data still remaining.
// - Payload is padded to whole doublewords.
// - The header carries the initiator's bus, device, function.
// - Data request control matches its header but Chain, DataError, Count.
module dmf_msg_frag
  import dmf_pkg::*;
#(
  parameter int FRAG_DW    = FRAG_ALIGN_DW,
  parameter bit HOST_NODE  = 1'b0,
  parameter bit XLATE_PORT = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  unit_id_i,
  input  wire logic [7:0]  own_bus_i,
  input  wire logic [4:0]  own_dev_i,
  input  wire logic [7:0]  sec_bus_i,
  input  wire logic [7:0]  fn_sup_i,
  input  wire logic        msg_vld_i,
  output logic             msg_rdy_o,
  input  wire logic [7:0]  msg_dbus_i,
  input  wire logic [4:0]  msg_ddev_i,
  input  wire logic [2:0]  msg_dfn_i,
  input  wire logic [2:0]  msg_sfn_i,
  input  wire logic        msg_type1_i,
  input  wire logic        msg_route_i,
  input  wire logic        msg_silent_i,
  input  wire logic        msg_xlate_i,
  input  wire logic        msg_nodat_i,
  input  wire logic [11:0] msg_bc_i,
  input  wire logic [39:0] msg_class_i,
  input  wire logic        src_vld_i,
  input  wire logic [31:0] src_dat_i,
  output logic             src_rdy_o,
  output logic             lk_tx_vld_o,
  output logic             lk_tx_ctl_o,
  output logic [63:0]      lk_tx_dat_o,
  input  wire logic        lk_tx_rdy_i,
  input  wire logic        lk_rx_vld_i,
  input  wire logic        lk_rx_ctl_i,
  input  wire logic [63:0] lk_rx_dat_i,
  output logic             lk_rx_rdy_o,
  output logic             dlv_vld_o,
  output logic [31:0]      dlv_dat_o,
  output logic             dlv_last_o,
  input  wire logic        dlv_rdy_i,
  output logic [63:0]      dlv_ctl_o,
  output logic             drop_o,
  output logic             unsup_err_o
);

  typedef struct packed {
    dmf_eng_e    e_st;
    logic        fwd;
    logic        first;
    logic [10:0] rem_dw;
    logic [12:0] rem_bc;
    logic [10:0] frag_dw;
    logic [4:0]  req_dw;
    logic [9:0]  rd_ptr;
    dmf_ctl_t    base;
    logic [31:0] hd0;
    logic [31:0] hd1;
    logic        tx_vld;
    logic        tx_ctl;
    logic [63:0] tx_dat;
    dmf_rx_e     r_st;
    dmf_ctl_t    r_ctl;
    logic [31:0] r_hd0;
    logic [31:0] r_hd1;
    logic [4:0]  r_cnt;
    logic        r_more;
    logic [10:0] wr_ptr;
    logic [10:0] dptr;
    logic        dl_vld;
    logic [31:0] dl_dat;
    logic        dl_last;
    logic        drop;
    logic        unsup;
  } dmf_state_s;

  dmf_state_s  s_ff;
  dmf_state_s  nxt_s;
  logic [31:0] mem [MSG_MAX_DW];
  logic        beat_vld;
  logic        beat_ctl;
  logic [63:0] beat_dat;
  logic        fire;
  logic        fwd_done;
  logic        rx_acc;
  logic        rt_loc;
  logic        rt_fwd;
  logic        rt_unsup;
  dmf_ctl_t    rt_ctl;

  //////////////////////////////////////////////////////////////////////////
  // Routing decision for the fragment sitting in the receive buffer.
  dmf_route #(
    .HOST_NODE  (HOST_NODE),
    .XLATE_PORT (XLATE_PORT)
  ) u_route (
    .ctl_i     (s_ff.r_ctl),
    .own_dev_i (own_dev_i),
    .sec_bus_i (sec_bus_i),
    .fn_sup_i  (fn_sup_i),
    .loc_o     (rt_loc),
    .fwd_o     (rt_fwd),
    .unsup_o   (rt_unsup),
    .ctl_o     (rt_ctl)
  );

  // Handshakes are combinational; all data leaves from the state register.
  assign msg_rdy_o   = s_ff.e_st == E_IDLE && s_ff.r_st != R_FWD;
  assign src_rdy_o   = s_ff.e_st == E_DDAT && !s_ff.fwd && (!s_ff.tx_vld || lk_tx_rdy_i);
  assign lk_rx_rdy_o = s_ff.r_st inside {R_CTL, R_HD0, R_HD1, R_DCTL, R_DDAT};
  assign rx_acc      = lk_rx_vld_i && lk_rx_rdy_o;
  assign lk_tx_vld_o = s_ff.tx_vld;
  assign lk_tx_ctl_o = s_ff.tx_ctl;
  assign lk_tx_dat_o = s_ff.tx_dat;
  assign dlv_vld_o   = s_ff.dl_vld;
  assign dlv_dat_o   = s_ff.dl_dat;
  assign dlv_last_o  = s_ff.dl_last;
  assign dlv_ctl_o   = s_ff.r_ctl;
  assign drop_o      = s_ff.drop;
  assign unsup_err_o = s_ff.unsup;

  //////////////////////////////////////////////////////////////////////////
  // Transmit engine and receive reassembly, one next-state computation.
  always_comb begin
    logic        setup;
    logic        frag_end;
    logic [12:0] bc13;
    nxt_s = s_ff;
    setup = 1'b0;
    frag_end = 1'b0;
    fwd_done = 1'b0;
    beat_vld = 1'b0;
    beat_ctl = 1'b0;
    beat_dat = 64'h0000_0000_0000_0000;
    bc13 = {msg_bc_i == 12'h000, msg_bc_i};
    nxt_s.drop = 1'b0;
    nxt_s.unsup = 1'b0;
    if (lk_tx_rdy_i) begin
      nxt_s.tx_vld = 1'b0;
    end
    // Beat offered by the engine in its current state.
    case (s_ff.e_st)
      E_HCTL: begin
        beat_vld = 1'b1;
        beat_ctl = 1'b1;
        beat_dat = dmf_set_cc(s_ff.base, s_ff.frag_dw != 11'h000, HDR_CNT);
      end
      E_HD0: begin
        beat_vld = 1'b1;
        beat_dat = {32'h0000_0000, s_ff.hd0};
      end
      E_HD1: begin
        beat_vld = 1'b1;
        beat_dat = {32'h0000_0000, s_ff.hd1};
      end
      E_DCTL: begin
        beat_vld = 1'b1;
        beat_ctl = 1'b1;
        beat_dat = dmf_set_cc(s_ff.base, s_ff.frag_dw != 11'(s_ff.req_dw),
                              4'(s_ff.req_dw - 5'h01));
      end
      E_DDAT: begin
        beat_vld = s_ff.fwd || src_vld_i;
        beat_dat = {32'h0000_0000, s_ff.fwd ? mem[s_ff.rd_ptr] : src_dat_i};
      end
      default: begin
        beat_vld = 1'b0;
      end
    endcase
    fire = beat_vld && (!s_ff.tx_vld || lk_tx_rdy_i);
    if (fire) begin
      nxt_s.tx_vld = 1'b1;
      nxt_s.tx_ctl = beat_ctl;
      nxt_s.tx_dat = beat_dat;
    end
    // Engine sequencing; a fragment is never interrupted once started.
    case (s_ff.e_st)
      E_IDLE: begin
        if (s_ff.r_st == R_FWD) begin
          nxt_s.fwd = 1'b1;
          nxt_s.base = s_ff.r_ctl;
          nxt_s.hd0 = s_ff.r_hd0;
          nxt_s.hd1 = s_ff.r_hd1;
          nxt_s.frag_dw = s_ff.wr_ptr;
          nxt_s.rem_dw = 11'h000;
          nxt_s.rd_ptr = 10'h000;
          nxt_s.e_st = E_HCTL;
        end else if (msg_vld_i) begin
          nxt_s.fwd = 1'b0;
          nxt_s.first = 1'b1;
          nxt_s.rem_bc = msg_nodat_i ? 13'h0000 : bc13;
          nxt_s.rem_dw = 11'((nxt_s.rem_bc + 13'h0003) >> 2);
          nxt_s.base = 64'h0000_0000_0000_0000;
          nxt_s.base[P_CMD+:6] = CMD_DEVMSG;
          nxt_s.base[P_AHI+:8] = ADDR_HI_DM;
          nxt_s.base[P_AMID+:3] = ADDR_MID_DM;
          nxt_s.base[P_UNIT+:5] = unit_id_i;
          nxt_s.base[P_SILENT] = msg_silent_i;
          nxt_s.base[P_ROUTE] = msg_route_i;
          nxt_s.base[P_XLATE] = msg_xlate_i;
          if (!msg_route_i) begin
            nxt_s.base[P_DFN+:3] = msg_dfn_i;
            nxt_s.base[P_DDEV+:5] = msg_ddev_i;
            nxt_s.base[P_DBUS+:8] = msg_dbus_i;
            nxt_s.base[P_TYPE] = msg_type1_i;
          end
          nxt_s.hd0 = {msg_class_i[7:0], 8'h00, own_bus_i, own_dev_i, msg_sfn_i};
          nxt_s.hd1 = msg_class_i[39:8];
          setup = 1'b1;
        end
      end
      E_HCTL: begin
        if (fire) begin
          nxt_s.e_st = E_HD0;
        end
      end
      E_HD0: begin
        if (fire) begin
          nxt_s.e_st = E_HD1;
        end
      end
      E_HD1: begin
        if (fire) begin
          if (s_ff.frag_dw != 11'h000) begin
            nxt_s.e_st = E_DCTL;
            nxt_s.req_dw = dmf_min16(s_ff.frag_dw);
          end else begin
            frag_end = 1'b1;
          end
        end
      end
      E_DCTL: begin
        if (fire) begin
          nxt_s.e_st = E_DDAT;
        end
      end
      E_DDAT: begin
        if (fire) begin
          nxt_s.frag_dw = s_ff.frag_dw - 11'h001;
          nxt_s.req_dw = s_ff.req_dw - 5'h01;
          nxt_s.rd_ptr = s_ff.rd_ptr + 10'h001;
          if (s_ff.req_dw == 5'h01) begin
            if (s_ff.frag_dw == 11'h001) begin
              frag_end = 1'b1;
            end else begin
              nxt_s.e_st = E_DCTL;
              nxt_s.req_dw = dmf_min16(s_ff.frag_dw - 11'h001);
            end
          end
        end
      end
      default: begin
        nxt_s.e_st = E_IDLE;
      end
    endcase
    if (frag_end) begin
      nxt_s.first = 1'b0;
      if (!s_ff.fwd && s_ff.rem_dw != 11'h000) begin
        setup = 1'b1;
      end else begin
        nxt_s.e_st = E_IDLE;
        fwd_done = s_ff.fwd;
      end
    end
    // Fragment setup: aligned size while more remains, and the bytes left.
    if (setup) begin
      nxt_s.frag_dw = (nxt_s.rem_dw > 11'(FRAG_DW)) ? 11'(FRAG_DW) : nxt_s.rem_dw;
      nxt_s.rem_dw = nxt_s.rem_dw - nxt_s.frag_dw;
      nxt_s.base[P_BCHI+:4] = nxt_s.rem_bc[11:8];
      nxt_s.hd0[H_BCLO+:8] = nxt_s.rem_bc[7:0];
      nxt_s.rem_bc = nxt_s.rem_bc - 13'({nxt_s.frag_dw, 2'b00});
      nxt_s.base[P_INIT] = nxt_s.first;
      nxt_s.e_st = E_HCTL;
    end
    // Receive side: one fragment at a time, stalled while it is handled.
    if (dlv_rdy_i) begin
      nxt_s.dl_vld = 1'b0;
    end
    case (s_ff.r_st)
      R_CTL: begin
        if (rx_acc && lk_rx_ctl_i && dmf_is_dm(lk_rx_dat_i)) begin
          nxt_s.r_ctl = lk_rx_dat_i;
          nxt_s.r_more = lk_rx_dat_i[P_CHAIN];
          nxt_s.wr_ptr = 11'h000;
          nxt_s.r_st = R_HD0;
        end
      end
      R_HD0: begin
        if (rx_acc && !lk_rx_ctl_i) begin
          nxt_s.r_hd0 = lk_rx_dat_i[31:0];
          nxt_s.r_st = R_HD1;
        end
      end
      R_HD1: begin
        if (rx_acc && !lk_rx_ctl_i) begin
          nxt_s.r_hd1 = lk_rx_dat_i[31:0];
          nxt_s.r_st = s_ff.r_more ? R_DCTL : R_DEC;
        end
      end
      R_DCTL: begin
        if (rx_acc && lk_rx_ctl_i) begin
          nxt_s.r_cnt = 5'(dmf_cnt(lk_rx_dat_i)) + 5'h01;
          nxt_s.r_more = lk_rx_dat_i[P_CHAIN];
          nxt_s.r_st = R_DDAT;
        end
      end
      R_DDAT: begin
        if (rx_acc && !lk_rx_ctl_i) begin
          nxt_s.wr_ptr = s_ff.wr_ptr + 11'h001;
          nxt_s.r_cnt = s_ff.r_cnt - 5'h01;
          if (s_ff.r_cnt == 5'h01) begin
            nxt_s.r_st = s_ff.r_more ? R_DCTL : R_DEC;
          end
        end
      end
      R_DEC: begin
        nxt_s.dptr = 11'h000;
        if (rt_loc) begin
          nxt_s.r_st = R_DLV;
        end else if (rt_fwd) begin
          nxt_s.r_ctl = rt_ctl;
          nxt_s.r_st = R_FWD;
        end else begin
          nxt_s.drop = 1'b1;
          nxt_s.unsup = rt_unsup;
          nxt_s.r_st = R_CTL;
        end
      end
      R_DLV: begin
        if (!s_ff.dl_vld || dlv_rdy_i) begin
          nxt_s.dl_vld = 1'b1;
          nxt_s.dl_dat = (s_ff.dptr == 11'h000) ? s_ff.r_hd0 :
                         (s_ff.dptr == 11'h001) ? s_ff.r_hd1 :
                         mem[10'(s_ff.dptr - 11'h002)];
          nxt_s.dl_last = s_ff.dptr == s_ff.wr_ptr + 11'h001;
          nxt_s.dptr = s_ff.dptr + 11'h001;
          if (nxt_s.dl_last) begin
            nxt_s.r_st = R_CTL;
          end
        end
      end
      R_FWD: begin
        if (fwd_done) begin
          nxt_s.r_st = R_CTL;
        end
      end
      default: begin
        nxt_s.r_st = R_CTL;
      end
    endcase
  end

  // State register; the whole block restarts idle and empty.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Fragment buffer, large enough for the longest fragment.
  always_ff @(posedge clk_i) begin
    if (s_ff.r_st == R_DDAT && rx_acc && !lk_rx_ctl_i) begin
      mem[s_ff.wr_ptr[9:0]] <= lk_rx_dat_i[31:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on what the engine and the reassembly logic produce.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  msg_len_a: assert property (s_ff.rem_dw <= 11'(MSG_MAX_DW))
    else $error("message longer than the maximum");
  hdr_only_a: assert property (fire && s_ff.e_st == E_HCTL |=>
    lk_tx_ctl_o && dmf_cnt(lk_tx_dat_o) == HDR_CNT ##1
    (!lk_tx_ctl_o || !lk_tx_vld_o || !$past(lk_tx_rdy_i)))
    else $error("header request has wrong count");
  frag_mult_a: assert property (fire && s_ff.e_st == E_HCTL && !s_ff.fwd &&
    s_ff.rem_dw != 11'h000 |-> s_ff.frag_dw % 11'(FRAG_ALIGN_DW) == 11'h000)
    else $error("non-final fragment not a multiple of 128 bytes");
  full_req_a: assert property (fire && s_ff.e_st == E_DCTL && !s_ff.fwd &&
    (beat_dat[P_CHAIN] || s_ff.rem_dw != 11'h000) |-> s_ff.req_dw == 5'(REQ_MAX_DW))
    else $error("short data request before the end");
  init_frag_a: assert property (fire && s_ff.e_st == E_HCTL && !s_ff.fwd |->
    beat_dat[P_INIT] == s_ff.first)
    else $error("initial fragment flag wrong");
  chain_bit_a: assert property (fire && s_ff.e_st == E_DCTL |->
    beat_dat[P_CHAIN] == (s_ff.frag_dw > 11'(s_ff.req_dw)))
    else $error("chain bit wrong on data request");
  no_data_a: assert property (fire && s_ff.e_st == E_HCTL &&
    s_ff.frag_dw == 11'h000 |-> !beat_dat[P_CHAIN])
    else $error("payload-less header has chain set");
  byte_cnt_a: assert property (fire && s_ff.e_st == E_HCTL && !s_ff.fwd |->
    {beat_dat[P_BCHI+:4], s_ff.hd0[H_BCLO+:8]} ==
    12'(s_ff.rem_bc + 13'({s_ff.frag_dw, 2'b00})))
    else $error("header byte count not the remaining data");
  ctl_match_a: assert property (fire && s_ff.e_st == E_DCTL |->
    dmf_set_cc(beat_dat, 1'b0, 4'h0) == dmf_set_cc(s_ff.base, 1'b0, 4'h0))
    else $error("data request fields differ from header");
  dm_addr_a: assert property (lk_tx_vld_o && lk_tx_ctl_o |->
    dmf_is_dm(lk_tx_dat_o))
    else $error("request outside device message range");
  atomic_a: assert property (s_ff.e_st != E_HCTL |-> $stable(s_ff.fwd))
    else $error("source changed inside a fragment");
  type0_a: assert property (s_ff.r_st == R_DEC && rt_fwd && !s_ff.r_ctl[P_ROUTE] &&
    s_ff.r_ctl[P_DBUS+:8] == sec_bus_i |=> !s_ff.r_ctl[P_TYPE])
    else $error("type 1 not converted on destination bus");
  silent_a: assert property (s_ff.r_st == R_DEC && s_ff.r_ctl[P_SILENT] |=>
    !unsup_err_o)
    else $error("silent drop logged an error");
  hold_rx_a: assert property (s_ff.r_st == R_DLV |-> !lk_rx_rdy_o)
    else $error("receive accepted while buffer busy");

  multi_frag_c: cover property (fire && s_ff.e_st == E_HCTL && !s_ff.first && !s_ff.fwd);
  fwd_c: cover property (fwd_done);
  local_c: cover property (dlv_vld_o && dlv_rdy_i && dlv_last_o);
  drop_c: cover property (drop_o);

endmodule

/* File: design/dmf_route.sv */
// Decides what a fully received fragment does at this node.
module dmf_route
  import dmf_pkg::*;
#(
  parameter bit HOST_NODE  = 1'b0,
  parameter bit XLATE_PORT = 1'b0
) (
  input  wire dmf_ctl_t    ctl_i,
  input  wire logic [4:0]  own_dev_i,
  input  wire logic [7:0]  sec_bus_i,
  input  wire logic [7:0]  fn_sup_i,
  output logic             loc_o,
  output logic             fwd_o,
  output logic             unsup_o,
  output dmf_ctl_t         ctl_o
);

  // Destination selection; the Type bit works like configuration cycles.
  always_comb begin
    logic loc;
    logic fwd;
    loc = 1'b0;
    fwd = 1'b0;
    ctl_o = ctl_i;
    unsup_o = 1'b0;
    if (ctl_i[P_ROUTE]) begin
      loc = HOST_NODE;
      fwd = !HOST_NODE;
    end else if (ctl_i[P_TYPE]) begin
      fwd = 1'b1;
      if (ctl_i[P_DBUS+:8] == sec_bus_i) begin
        ctl_o[P_TYPE] = 1'b0;
      end
    end else if (ctl_i[P_DDEV+:5] == own_dev_i) begin
      loc = fn_sup_i[ctl_i[P_DFN+:3]];
      unsup_o = !loc && !ctl_i[P_SILENT];
    end else begin
      fwd = 1'b1;
    end
    // A translating port refuses messages that may not cross bus families.
    if (XLATE_PORT && !ctl_i[P_XLATE]) begin
      fwd = 1'b0;
    end
    loc_o = loc;
    fwd_o = fwd;
  end

endmodule

/* File: inc/dmf_pkg.sv */
package dmf_pkg;

  // Message and request sizes.
  localparam int MSG_MAX_BYTES    = 4096;
  localparam int FRAG_ALIGN_BYTES = 128;
  localparam int REQ_MAX_BYTES    = 64;
  localparam int DW_BYTES         = 4;
  localparam int MSG_MAX_DW       = MSG_MAX_BYTES / DW_BYTES;
  localparam int FRAG_ALIGN_DW    = FRAG_ALIGN_BYTES / DW_BYTES;
  localparam int REQ_MAX_DW       = REQ_MAX_BYTES / DW_BYTES;

  //////////////////////////////////////////////////////////////////////////
  // Control packet field positions (bit-time n sits at bits 8n+7:8n).
  localparam int P_CMD    = 0;
  localparam int P_UNIT   = 8;
  localparam int P_CHAIN  = 19;
  localparam int P_DERR   = 20;
  localparam int P_CNTLO  = 22;
  localparam int P_CNTHI  = 24;
  localparam int P_INIT   = 26;
  localparam int P_SILENT = 27;
  localparam int P_ROUTE  = 28;
  localparam int P_XLATE  = 29;
  localparam int P_DFN    = 32;
  localparam int P_DDEV   = 35;
  localparam int P_DBUS   = 40;
  localparam int P_BCHI   = 48;
  localparam int P_TYPE   = 52;
  localparam int P_AMID   = 53;
  localparam int P_AHI    = 56;

  // Header payload positions in its first doubleword.
  localparam int H_SFN  = 0;
  localparam int H_SDEV = 3;
  localparam int H_SBUS = 8;
  localparam int H_BCLO = 16;
  localparam int H_CLS  = 24;

  // Fixed codes of a device message request.
  localparam logic [5:0] CMD_DEVMSG  = 6'h2C;
  localparam logic [7:0] ADDR_HI_DM  = 8'hFE;
  localparam logic [2:0] ADDR_MID_DM = 3'h0;
  localparam logic [3:0] HDR_CNT     = 4'h1;

  typedef logic [63:0] dmf_ctl_t;

  typedef enum logic [2:0] {E_IDLE, E_HCTL, E_HD0, E_HD1, E_DCTL, E_DDAT} dmf_eng_e;
  typedef enum logic [2:0] {R_CTL, R_HD0, R_HD1, R_DCTL, R_DDAT, R_DEC, R_DLV,
                            R_FWD} dmf_rx_e;

  // Replace Chain, DataError and Count of a control packet.
  function automatic dmf_ctl_t dmf_set_cc(dmf_ctl_t c, logic chain, logic [3:0] cnt);
    dmf_ctl_t r;
    r = c;
    r[P_CHAIN] = chain;
    r[P_DERR] = 1'b0;
    r[P_CNTLO+:2] = cnt[1:0];
    r[P_CNTHI+:2] = cnt[3:2];
    return r;
  endfunction

  function automatic logic [3:0] dmf_cnt(dmf_ctl_t c);
    return {c[P_CNTHI+:2], c[P_CNTLO+:2]};
  endfunction

  // A posted write into the device message address range.
  function automatic logic dmf_is_dm(dmf_ctl_t c);
    return c[P_CMD+2+:4] == CMD_DEVMSG[5:2] && c[P_AHI+:8] == ADDR_HI_DM &&
           c[P_AMID+:3] == ADDR_MID_DM;
  endfunction

  function automatic logic [4:0] dmf_min16(logic [10:0] n);
    return (n > 11'(REQ_MAX_DW)) ? 5'(REQ_MAX_DW) : n[4:0];
  endfunction

endpackage

/* File: testbench/dmf_link_node.sv */
////////////////////////////////////////////////////////////////////////////////
// Far link node: it takes outbound beats and sends inbound beats.
module dmf_link_node (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        tx_vld_i,
  input  wire logic        tx_ctl_i,
  input  wire logic [63:0] tx_dat_i,
  output logic             tx_rdy_o,
  output logic             rx_vld_o,
  output logic             rx_ctl_o,
  output logic [63:0]      rx_dat_o,
  input  wire logic        rx_rdy_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [64:0] cap_q[$];

  // Idle lines at time zero.
  initial begin
    tx_rdy_o = 1'b1;
    rx_vld_o = 1'b0;
    rx_ctl_o = 1'b0;
    rx_dat_o = 64'h0000_0000_0000_0000;
  end

  // Beats are kept in arrival order; slow mode takes only every other cycle.
  always @(posedge clk_i) begin
    if (tx_vld_i && tx_rdy_o) cap_q.push_back({tx_ctl_i, tx_dat_i});
    tx_rdy_o <= slow_i ? !tx_rdy_o : 1'b1;
  end

  // A beat stays up until taken, so a fragment leaves with no gap for others.
  task automatic put(input logic ctl, input logic [63:0] dat);
    rx_vld_o <= 1'b1;
    rx_ctl_o <= ctl;
    rx_dat_o <= dat;
    do @(posedge clk_i); while (rx_rdy_i !== 1'b1);
  endtask

  // Released data flips, so a stale beat can never pass for a fresh one.
  task automatic quiet();
    rx_vld_o <= 1'b0;
    rx_dat_o <= ~rx_dat_o;
  endtask
endmodule

/* File: testbench/testbench.sv */
module testbench
  import dmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FB = 128;
  logic        clk_i, rst_i, slow, msg_vld_i, msg_rdy_o, src_vld_i, src_rdy_o;
  logic        dlv_vld_o, dlv_last_o, dlv_rdy_i, drop_o, unsup_err_o;
  logic        tx_vld, tx_ctl, tx_rdy, rx_vld, rx_ctl, rx_rdy;
  logic [7:0]  k, fns;
  localparam logic [31:0] DV [4] = '{32'h7708_4411, 32'hC1A5_5EED, 32'hDA7A_0000,
                                     32'hDA7A_0001};
  logic [4:0]  fl;
  logic [11:0] msg_bc_i;
  logic [31:0] src_dat_i, dlv_dat_o;
  logic [63:0] tx_dat, rx_dat, dlv_ctl_o;
  logic [32:0] dlv_q[$];
  int          mismatches, tests_run, cycles, drops, errs;

  dmf_msg_frag #(.FRAG_DW(32)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .unit_id_i(5'h06),
    .own_bus_i(8'h11), .own_dev_i(5'h03), .sec_bus_i(8'h35), .fn_sup_i(fns),
    .msg_vld_i(msg_vld_i), .msg_rdy_o(msg_rdy_o), .msg_dbus_i(k), .msg_ddev_i(k[4:0]),
    .msg_dfn_i(k[2:0]), .msg_sfn_i(~k[2:0]), .msg_type1_i(fl[1]), .msg_route_i(fl[4]),
    .msg_silent_i(fl[2]), .msg_xlate_i(fl[3]), .msg_nodat_i(fl[0]), .msg_bc_i(msg_bc_i),
    .msg_class_i({k, 32'h89AB_CDEF}), .src_vld_i(src_vld_i), .src_dat_i(src_dat_i),
    .src_rdy_o(src_rdy_o), .lk_tx_vld_o(tx_vld), .lk_tx_ctl_o(tx_ctl), .lk_tx_dat_o(tx_dat),
    .lk_tx_rdy_i(tx_rdy), .lk_rx_vld_i(rx_vld), .lk_rx_ctl_i(rx_ctl), .lk_rx_dat_i(rx_dat),
    .lk_rx_rdy_o(rx_rdy), .dlv_vld_o(dlv_vld_o), .dlv_dat_o(dlv_dat_o),
    .dlv_last_o(dlv_last_o), .dlv_rdy_i(dlv_rdy_i), .dlv_ctl_o(dlv_ctl_o), .drop_o(drop_o),
    .unsup_err_o(unsup_err_o));
  dmf_link_node i_node (.clk_i(clk_i), .slow_i(slow), .tx_vld_i(tx_vld), .tx_ctl_i(tx_ctl),
    .tx_dat_i(tx_dat), .tx_rdy_o(tx_rdy), .rx_vld_o(rx_vld), .rx_ctl_o(rx_ctl),
    .rx_dat_o(rx_dat), .rx_rdy_i(rx_rdy));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, a hang guard and the stalling payload source and delivery sink.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end
  always @(posedge clk_i) begin
    if (msg_vld_i && msg_rdy_o) src_dat_i <= 32'hA5A5_0000;
    else if (src_vld_i && src_rdy_o) src_dat_i <= src_dat_i + 32'h0000_0001;
    src_vld_i <= !src_vld_i || !src_rdy_o;
    dlv_rdy_i <= ~dlv_rdy_i;
    if (dlv_vld_o && dlv_rdy_i) dlv_q.push_back({dlv_last_o, dlv_dat_o});
    if (!rst_i) drops += int'(drop_o);
    if (!rst_i) errs += int'(unsup_err_o);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [64:0] got, input logic [64:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [64:0] pop();
    return (i_node.cap_q.size() > 0) ? i_node.cap_q.pop_front() : 65'h0;
  endfunction

  // Sends one message and rebuilds every beat that must leave on the link.
  task automatic tx_msg(input logic [7:0] kk, input logic [11:0] bc, input logic [4:0] f);
    logic [63:0] e;
    logic [64:0] g;
    int          rem, fdw, n, d;
    @(posedge clk_i);
    k <= kk;
    fl <= f;
    msg_bc_i <= bc;
    msg_vld_i <= 1'b1;
    do @(posedge clk_i); while (msg_rdy_o !== 1'b1);
    msg_vld_i <= 1'b0;
    do @(posedge clk_i); while (msg_rdy_o !== 1'b1);
    repeat (6) @(posedge clk_i);
    rem = f[0] ? 0 : ((bc == 12'h000) ? 4096 : int'(bc));
    d = 0;
    e = 64'h0000_0000_0000_0000;
    e[P_INIT] = 1'b1;
    do begin
      g = pop();
      fdw = ((rem > FB ? FB : rem) + 3) / 4;
      e[P_CMD+:6] = CMD_DEVMSG;
      e[P_AHI+:8] = ADDR_HI_DM;
      e[P_UNIT+:5] = 5'h06;
      e[P_CHAIN] = fdw != 0;
      {e[P_CNTHI+:2], e[P_CNTLO+:2]} = 4'h1;
      {e[P_XLATE], e[P_ROUTE], e[P_SILENT], e[P_TYPE]} = {f[3], f[4], f[2], f[1]};
      e[P_DFN+:16] = f[4] ? g[P_DFN+:16] : {kk, kk[4:0], kk[2:0]};
      e[P_BCHI+:4] = 4'(rem >> 8);
      chk("header", g, {1'b1, e});
      chk("hdr_dw0", pop(), {33'h0, 8'hEF, 8'(rem), 8'h11, 5'h03, ~kk[2:0]});
      chk("hdr_dw1", pop(), {33'h0, kk, 24'h89_ABCD});
      while (fdw > 0) begin
        n = (fdw > 16) ? 16 : fdw;
        fdw -= n;
        e[P_CHAIN] = fdw != 0;
        {e[P_CNTHI+:2], e[P_CNTLO+:2]} = 4'(n - 1);
        chk("data_ctl", pop(), {1'b1, e});
        repeat (n) begin
          chk("data", pop(), {33'h0, 32'hA5A5_0000 + 32'(d)});
          d++;
        end
      end
      rem -= (rem > FB) ? FB : rem;
      e[P_INIT] = 1'b0;
    end while (rem > 0);
    chk("extra_beats", 65'(i_node.cap_q.size()), 65'h0);
  endtask

  // Sends a two-dword fragment into the block from the far node.
  task automatic rx_frag(input logic [15:0] dst, input logic t1, input logic sl,
                         input logic rt);
    logic [63:0] c;
    c = 64'h0000_0000_0000_0000;
    c[P_CMD+:6] = CMD_DEVMSG;
    c[P_AHI+:8] = ADDR_HI_DM;
    c[P_CNTLO+:2] = 2'h1;
    {c[P_CHAIN], c[P_INIT], c[P_SILENT], c[P_ROUTE], c[P_TYPE]} = {2'h3, sl, rt, t1};
    c[P_DFN+:16] = dst;
    @(posedge clk_i);
    i_node.put(1'b1, c);
    i_node.put(1'b0, {32'h0, 32'h7708_4411});
    i_node.put(1'b0, {32'h0, 32'hC1A5_5EED});
    c[P_CHAIN] = 1'b0;
    i_node.put(1'b1, c);
    i_node.put(1'b0, {32'h0, 32'hDA7A_0000});
    i_node.put(1'b0, {32'h0, 32'hDA7A_0001});
    i_node.quiet();
    repeat (30) @(posedge clk_i);
  endtask

  // A forwarded fragment leaves whole; type 1 turns to type 0 on its own bus.
  task automatic fwd(input logic [7:0] bus, input logic t1, input logic rt, input logic ty);
    rx_frag({bus, 8'h21}, t1, 1'b0, rt);
    chk("fwd_beats", 65'(i_node.cap_q.size()), 65'h6);
    chk("fwd_type", 65'(i_node.cap_q[0][P_TYPE]), 65'(ty));
    chk("fwd_data", i_node.cap_q[5], {33'h0, 32'hDA7A_0001});
    i_node.cap_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: outbound messages, then inbound delivery, drops and forwards.
  initial begin
    {rst_i, slow, msg_vld_i, src_vld_i, dlv_rdy_i} = 5'h10;
    {k, fl, msg_bc_i, src_dat_i} = '0;
    fns = 8'h04;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    tx_msg(8'h21, 12'h008, 5'h0A);
    tx_msg(8'h42, 12'h5A5, 5'h01);
    slow <= 1'b1;
    tx_msg(8'h63, 12'h081, 5'h04);
    tx_msg(8'h84, 12'h000, 5'h02);
    slow <= 1'b0;
    tx_msg(8'hA6, 12'hFFF, 5'h00);
    tx_msg(8'h05, 12'h003, 5'h10);
    rx_frag(16'h001A, 1'b0, 1'b0, 1'b0);
    chk("dlv_count", 65'(dlv_q.size()), 65'h4);
    foreach (dlv_q[i]) chk("deliver", 65'(dlv_q[i]), {32'h0, i == 3, DV[i]});
    dlv_q.delete();
    chk("dlv_fn", 65'(dlv_ctl_o[P_DFN+:3]), 65'h2);
    rx_frag(16'h0019, 1'b0, 1'b0, 1'b0);
    chk("err_loud", 65'(errs), 65'h1);
    rx_frag(16'h0019, 1'b0, 1'b1, 1'b0);
    chk("err_silent", 65'(errs), 65'h1);
    chk("drops", 65'(drops), 65'h2);
    fns <= 8'h02;
    rx_frag(16'h0019, 1'b0, 1'b0, 1'b0);
    chk("dlv_fn1", 65'(dlv_q.size()), 65'h4);
    fwd(8'h35, 1'b1, 1'b0, 1'b0);
    fwd(8'h40, 1'b1, 1'b0, 1'b1);
    fwd(8'h40, 1'b0, 1'b1, 1'b0);
    end_of_test();
  end
endmodule
